// ---- core/cpu_video_access_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_video_access_port_defs.svh"
module cpu_video_access_port #(
  parameter int SLOT_CYCLES = `SLOT_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [19:0] addr_i,
  input wire logic io_strobe_i,
  input wire logic out_status_i,
  input wire logic mem_read_i,
  input wire logic mem_write_i,
  input wire logic data_in_strobe_i,
  input wire logic [7:0] write_data_i,
  input wire logic peripheral_bus_clock_i,
  input wire logic [7:0] display_ctrl_data_i,
  input wire logic [7:0] lightpen_data_i,
  input wire logic [15:0] scan_addr_i,
  input wire logic [7:0] vram_data_red_i,
  input wire logic [7:0] vram_data_green_i,
  input wire logic [7:0] vram_data_blue_i,
  input wire logic [2:0] dot_i,
  output logic display_ctrl_select_o,
  output logic adapter_select_o,
  output logic readback_select_o,
  output logic lightpen_counter_select_o,
  output logic video_io_read_select_o,
  output logic read_buffer_enable_o,
  output logic [7:0] readback_bus_o,
  output logic red_bank_select_o,
  output logic green_bank_select_o,
  output logic blue_bank_select_o,
  output logic vram_request_o,
  output logic phantom_o,
  output logic vram_ready_out_o,
  output logic vram_address_owner_o,
  output logic [15:0] vram_address_bus_o,
  output logic [2:0] vram_write_o,
  output logic [7:0] vram_write_data_o,
  output logic fast_clear_o,
  output logic [2:0] color_o
);
  import cpu_video_access_port_pkg::*;

  generate
    if (SLOT_CYCLES < 2)
    begin : g_bad_slot
      $error("SLOT_CYCLES must be at least 2");
    end
  endgenerate

  localparam int CW = $clog2(SLOT_CYCLES);

  function automatic logic port_match(input logic [7:0] a, input logic [7:0] base,
                                      input logic [7:0] mask);
    port_match = (a & mask) == (base & mask);
  endfunction

  logic disp_hit;
  logic adpt_hit;
  logic lpen_hit;
  logic [2:0] bank_hit;
  logic [15:0] mapped;
  logic [7:0] adpt_rdata;
  logic [7:0] port_a;
  logic [7:0] offset;
  logic bank_en;
  logic [2:0] req_bank;
  logic req_c;
  logic peripheral_bus_clock_q;
  logic peripheral_bus_clock_fall;
  logic adpt_wr;
  logic [CW-1:0] cyc;
  logic [1:0] slot;
  logic slot_end;
  logic cpu_start;
  arb_state_t state;
  arb_state_t next_state;
  logic next_owner;
  logic [7:0] latch_red;
  logic [7:0] latch_green;
  logic [7:0] latch_blue;
  logic [7:0] next_readback;
  logic [2:0] mirror;

  // Port decode
  always_comb
  begin
    disp_hit = io_strobe_i & port_match(addr_i[7:0], `IO_DISP_BASE, `IO_DISP_MASK);
    adpt_hit = io_strobe_i & port_match(addr_i[7:0], `IO_ADPT_BASE, `IO_ADPT_MASK);
    lpen_hit = io_strobe_i & port_match(addr_i[7:0], `IO_LPEN_BASE, `IO_LPEN_MASK);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      display_ctrl_select_o <= 1'b0;
      adapter_select_o <= 1'b0;
      readback_select_o <= 1'b0;
      lightpen_counter_select_o <= 1'b0;
      video_io_read_select_o <= 1'b0;
      read_buffer_enable_o <= 1'b0;
    end
    else
    begin
      display_ctrl_select_o <= disp_hit;
      adapter_select_o <= adpt_hit;
      lightpen_counter_select_o <= lpen_hit;
      readback_select_o <= disp_hit | adpt_hit;
      video_io_read_select_o <= disp_hit | adpt_hit | lpen_hit;
      read_buffer_enable_o <= (disp_hit | adpt_hit | lpen_hit) & data_in_strobe_i;
    end
  end

  // Adapter writes land on the falling edge of the peripheral bus clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      peripheral_bus_clock_q <= 1'b0;
    else
      peripheral_bus_clock_q <= peripheral_bus_clock_i;
  end

  assign peripheral_bus_clock_fall = peripheral_bus_clock_q & ~peripheral_bus_clock_i;
  assign adpt_wr = peripheral_bus_clock_fall & adpt_hit & out_status_i;

  adapter_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(adpt_wr),
    .index_i(addr_i[1:0]),
    .wdata_i(write_data_i),
    .rdata_o(adpt_rdata),
    .port_a_o(port_a),
    .offset_o(offset),
    .fast_clear_o(fast_clear_o)
  );

  window_map u_map (
    .addr_i(addr_i),
    .offset_i(offset),
    .hit_o(bank_hit),
    .mapped_o(mapped)
  );

  // Bank decode and request
  assign bank_en = port_a[`PA_BANK_EN];
  assign req_bank = bank_en && (mem_read_i || mem_write_i) && !out_status_i
                    ? bank_hit : 3'h0;
  assign req_c = |req_bank;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      red_bank_select_o <= 1'b0;
      green_bank_select_o <= 1'b0;
      blue_bank_select_o <= 1'b0;
      vram_request_o <= 1'b0;
      phantom_o <= 1'b0;
    end
    else
    begin
      red_bank_select_o <= req_bank[`BANK_RED];
      green_bank_select_o <= req_bank[`BANK_GREEN];
      blue_bank_select_o <= req_bank[`BANK_BLUE];
      vram_request_o <= req_c;
      phantom_o <= req_c;
    end
  end

  // Slot timing: slots 0 and 1 belong to the display controller
  assign slot_end = cyc == CW'(SLOT_CYCLES - 1);
  assign cpu_start = slot_end && slot == `SLOT_PRE_CPU;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cyc <= '0;
      slot <= `SLOT_FIRST;
    end
    else if (slot_end)
    begin
      cyc <= '0;
      slot <= slot == `SLOT_CPU ? `SLOT_FIRST : slot + 2'h1;
    end
    else
    begin
      cyc <= cyc + CW'(1);
    end
  end

  // Arbitration; the CPU is expected to hold its request while waiting
  always_comb
  begin
    next_state = state;
    unique case (state)
      ARB_IDLE:
        if (req_c)
          next_state = ARB_WAIT;
      ARB_WAIT:
        if (!req_c)
          next_state = ARB_IDLE;
        else if (cpu_start)
          next_state = ARB_ACCESS;
      ARB_ACCESS:
        if (slot_end)
          next_state = ARB_DONE;
      ARB_DONE:
        if (!req_c)
          next_state = ARB_IDLE;
    endcase
    next_owner = next_state == ARB_ACCESS;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ARB_IDLE;
    else
      state <= next_state;
  end

  // Ready rises as the CPU slot completes, so a waiting access never
  // sees it high before its data are latched
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      vram_ready_out_o <= 1'b1;
    else
      vram_ready_out_o <= !req_c || next_state == ARB_DONE;
  end

  assign mirror = {~port_a[`PA_WR_BLUE_N], ~port_a[`PA_WR_GREEN_N],
                   ~port_a[`PA_WR_RED_N]};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vram_address_owner_o <= 1'b0;
      vram_address_bus_o <= 16'h0000;
      vram_write_o <= 3'h0;
      vram_write_data_o <= `BYTE_ZERO;
    end
    else
    begin
      vram_address_owner_o <= next_owner;
      vram_address_bus_o <= next_owner ? mapped : scan_addr_i;
      vram_write_o <= next_owner && mem_write_i ? req_bank | mirror : 3'h0;
      vram_write_data_o <= write_data_i;
    end
  end

  // Read latches catch the bank data at the end of the CPU slot
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      latch_red <= `BYTE_ZERO;
      latch_green <= `BYTE_ZERO;
      latch_blue <= `BYTE_ZERO;
    end
    else if (state == ARB_ACCESS && slot_end && mem_read_i)
    begin
      if (req_bank[`BANK_RED])
        latch_red <= vram_data_red_i;
      if (req_bank[`BANK_GREEN])
        latch_green <= vram_data_green_i;
      if (req_bank[`BANK_BLUE])
        latch_blue <= vram_data_blue_i;
    end
  end

  always_comb
  begin
    next_readback = `BYTE_ZERO;
    if (data_in_strobe_i)
    begin
      if (disp_hit)
        next_readback = display_ctrl_data_i;
      else if (adpt_hit)
        next_readback = adpt_rdata;
      else if (lpen_hit)
        next_readback = lightpen_data_i;
      else if (req_bank[`BANK_RED])
        next_readback = latch_red;
      else if (req_bank[`BANK_GREEN])
        next_readback = latch_green;
      else if (req_bank[`BANK_BLUE])
        next_readback = latch_blue;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      readback_bus_o <= `BYTE_ZERO;
    else
      readback_bus_o <= next_readback;
  end

  // Colour gating never touches memory contents
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      color_o <= 3'h0;
    else
      color_o <= port_a[`PA_EN_BLUE:`PA_EN_RED]
                 & ({3{port_a[`PA_SATURATE]}} | dot_i);
  end

  property p_disp_sel;
    @(posedge clk_i) disable iff (rst_i)
      disp_hit |=> display_ctrl_select_o && !lightpen_counter_select_o;
  endproperty
  a_disp_sel: assert property (p_disp_sel)
    else $error("display controller select missing");

  property p_readback_or;
    @(posedge clk_i) disable iff (rst_i)
      readback_select_o == (display_ctrl_select_o || adapter_select_o);
  endproperty
  a_readback_or: assert property (p_readback_or)
    else $error("readback select is not the OR");

  property p_lpen;
    @(posedge clk_i) disable iff (rst_i)
      lightpen_counter_select_o |-> $past(lpen_hit);
  endproperty
  a_lpen: assert property (p_lpen)
    else $error("light-pen select without its port");

  property p_buffer;
    @(posedge clk_i) disable iff (rst_i)
      read_buffer_enable_o |-> video_io_read_select_o && $past(data_in_strobe_i);
  endproperty
  a_buffer: assert property (p_buffer)
    else $error("read buffer enabled without a select");

  property p_no_bank_on_out;
    @(posedge clk_i) disable iff (rst_i)
      out_status_i || !bank_en |=> !vram_request_o && !phantom_o;
  endproperty
  a_no_bank_on_out: assert property (p_no_bank_on_out)
    else $error("bank request during output or disabled");

  property p_wait;
    @(posedge clk_i) disable iff (rst_i)
      state == ARB_WAIT && req_c |=> !vram_ready_out_o;
  endproperty
  a_wait: assert property (p_wait)
    else $error("ready high while waiting for slot");

  property p_owner_slot;
    @(posedge clk_i) disable iff (rst_i)
      vram_address_owner_o |-> slot == `SLOT_CPU;
  endproperty
  a_owner_slot: assert property (p_owner_slot)
    else $error("CPU owns RAM outside its slot");

  property p_map;
    @(posedge clk_i) disable iff (rst_i)
      vram_address_owner_o |-> vram_address_bus_o[7:0] == $past(addr_i[7:0])
        && vram_address_bus_o[15:8] == 8'($past(addr_i[15:8]) + $past(offset));
  endproperty
  a_map: assert property (p_map)
    else $error("mapped address wrong on video bus");

  property p_scan;
    @(posedge clk_i) disable iff (rst_i)
      !vram_address_owner_o && !$past(rst_i) |-> vram_address_bus_o == $past(scan_addr_i);
  endproperty
  a_scan: assert property (p_scan)
    else $error("scan address not routed");
endmodule
`default_nettype wire

// ---- core/cpu_video_access_port_defs.svh ----
`ifndef CPU_VIDEO_ACCESS_PORT_DEFS_SVH
`define CPU_VIDEO_ACCESS_PORT_DEFS_SVH

// I/O port windows: base and match mask on the low eight address bits
`define IO_DISP_BASE 8'hdc
`define IO_DISP_MASK 8'hfe
`define IO_ADPT_BASE 8'hd8
`define IO_ADPT_MASK 8'hfc
`define IO_LPEN_BASE 8'hde
`define IO_LPEN_MASK 8'hff

// Upper nibble of the CPU address for each colour bank
`define BANK_NIB_RED 4'hd
`define BANK_NIB_GREEN 4'he
`define BANK_NIB_BLUE 4'hc

// Bank index inside three-bit bank vectors
`define BANK_RED 0
`define BANK_GREEN 1
`define BANK_BLUE 2

// Adapter register indexes
`define REG_PORT_A 2'h0
`define REG_OFFSET 2'h1
`define REG_MISC 2'h2
`define REG_DIR 2'h3

// Port A fields
`define PA_EN_RED 0
`define PA_EN_GREEN 1
`define PA_EN_BLUE 2
`define PA_SATURATE 3
`define PA_WR_RED_N 4
`define PA_WR_GREEN_N 5
`define PA_WR_BLUE_N 6
`define PA_BANK_EN 7
// Inactive level of port A: mirror writes are active low
`define PORT_A_IDLE 8'h70
`define BYTE_ZERO 8'h00
`define MISC_CLEAR 0
`define DIR_A 0
`define DIR_B 1
`define DIR_C 2

// Memory timing: three slots, display owns two, CPU the last
`define SLOT_CYCLES_DEF 4
`define SLOT_FIRST 2'h0
`define SLOT_PRE_CPU 2'h1
`define SLOT_CPU 2'h2

`endif

// ---- core/cpu_video_access_port_pkg.sv ----
`default_nettype none
package cpu_video_access_port_pkg;
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_WAIT,
    ARB_ACCESS,
    ARB_DONE
  } arb_state_t;
endpackage
`default_nettype wire

// ---- core/adapter_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_video_access_port_defs.svh"
module adapter_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [1:0] index_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [7:0] port_a_o,
  output logic [7:0] offset_o,
  output logic fast_clear_o
);
  import cpu_video_access_port_pkg::*;

  logic [7:0] mem [4];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem[`REG_PORT_A] <= `PORT_A_IDLE;
      mem[`REG_OFFSET] <= `BYTE_ZERO;
      mem[`REG_MISC] <= `BYTE_ZERO;
      mem[`REG_DIR] <= `BYTE_ZERO;
    end
    else if (wr_en_i)
    begin
      mem[index_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= `BYTE_ZERO;
    else
      rdata_o <= mem[index_i];
  end

  // A line left as input floats to its inactive level, so nothing fires
  // before software has turned the port into outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_a_o <= `PORT_A_IDLE;
      offset_o <= `BYTE_ZERO;
      fast_clear_o <= 1'b0;
    end
    else
    begin
      port_a_o <= mem[`REG_DIR][`DIR_A] ? mem[`REG_PORT_A] : `PORT_A_IDLE;
      offset_o <= mem[`REG_DIR][`DIR_B] ? mem[`REG_OFFSET] : `BYTE_ZERO;
      fast_clear_o <= mem[`REG_DIR][`DIR_C] & mem[`REG_MISC][`MISC_CLEAR];
    end
  end

  property p_reset_idle;
    @(posedge clk_i) rst_i |=> port_a_o == `PORT_A_IDLE && !fast_clear_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("adapter lines not inactive after reset");
endmodule
`default_nettype wire

// ---- core/window_map.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_video_access_port_defs.svh"
module window_map (
  input wire logic [19:0] addr_i,
  input wire logic [7:0] offset_i,
  output logic [2:0] hit_o,
  output logic [15:0] mapped_o
);
  import cpu_video_access_port_pkg::*;

  logic [7:0] upper;

  always_comb
  begin
    hit_o = 3'h0;
    hit_o[`BANK_RED] = addr_i[19:16] == `BANK_NIB_RED;
    hit_o[`BANK_GREEN] = addr_i[19:16] == `BANK_NIB_GREEN;
    hit_o[`BANK_BLUE] = addr_i[19:16] == `BANK_NIB_BLUE;
    upper = addr_i[15:8] + offset_i;
    mapped_o = {upper, addr_i[7:0]};
  end
endmodule
`default_nettype wire

// ---- bench/cpu_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic [19:0] addr_o,
  output logic io_strobe_o,
  output logic out_status_o,
  output logic mem_read_o,
  output logic mem_write_o,
  output logic data_in_strobe_o,
  output logic [7:0] write_data_o,
  output logic peripheral_bus_clock_o
);
  initial
  begin
    addr_o = 20'h0_0000;
    io_strobe_o = 1'h0;
    out_status_o = 1'h0;
    mem_read_o = 1'h0;
    mem_write_o = 1'h0;
    data_in_strobe_o = 1'h0;
    write_data_o = 8'h00;
    peripheral_bus_clock_o = 1'h0;
  end
  task automatic io_start(input logic [7:0] port, input logic wr, input logic [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= {12'h000, port};
      io_strobe_o <= 1'h1;
      out_status_o <= wr;
      data_in_strobe_o <= ~wr;
      write_data_o <= d;
      peripheral_bus_clock_o <= 1'h1;
      repeat (2) @(posedge clk_i);
      peripheral_bus_clock_o <= 1'h0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  // Released data shows its inverse so a stale byte never looks live
  task automatic bus_stop;
    begin
      @(posedge clk_i);
      io_strobe_o <= 1'h0;
      out_status_o <= 1'h0;
      mem_read_o <= 1'h0;
      mem_write_o <= 1'h0;
      data_in_strobe_o <= 1'h0;
      write_data_o <= ~write_data_o;
    end
  endtask
  // Request stays up through the wait states; ok only if ready dropped and came back
  task automatic mem_start(input logic [19:0] a, input logic wr, input logic outc,
                           input logic [7:0] d, output logic ok);
    int n;
    logic low;
    begin
      @(posedge clk_i);
      addr_o <= a;
      mem_write_o <= wr;
      mem_read_o <= ~wr;
      out_status_o <= outc;
      data_in_strobe_o <= ~wr;
      write_data_o <= d;
      low = 1'h0;
      for (n = 0; n < 80; n++)
      begin
        @(posedge clk_i);
        if (ready_i === 1'h0)
          low = 1'h1;
        if (low && ready_i === 1'h1)
          break;
        if (!low && n > 4)
          break;
      end
      ok = low & (ready_i === 1'h1);
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/cpu_video_access_port_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
      n_mismatch++; \
    end \
  end
module cpu_video_access_port_bench;
  localparam int SLOTS = 3;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int own_cnt = 0;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [19:0] addr_i;
  logic io_strobe_i, out_status_i, mem_read_i, mem_write_i, data_in_strobe_i, peripheral_bus_clock;
  logic [7:0] write_data_i;
  logic [7:0] display_ctrl_data_i = 8'h00;
  logic [7:0] lightpen_data_i = 8'h00;
  logic [15:0] scan_addr_i = 16'h1234;
  logic [7:0] vram_data_red_i = 8'h00;
  logic [7:0] vram_data_green_i = 8'h00;
  logic [7:0] vram_data_blue_i = 8'h00;
  logic [2:0] dot_i = 3'h0;
  logic display_ctrl_select_o, adapter_select_o, readback_select_o, lightpen_counter_select_o;
  logic video_io_read_select_o, read_buffer_enable_o, red_bank_select_o, green_bank_select_o;
  logic blue_bank_select_o, vram_request_o, phantom_o, vram_ready_out_o, vram_address_owner_o;
  logic fast_clear_o;
  logic [7:0] readback_bus_o, vram_write_data_o;
  logic [15:0] vram_address_bus_o, abus_seen;
  logic [2:0] vram_write_o, color_o, wr_seen;

  always #2.5 clk_i = ~clk_i;

  cpu_video_access_port #(.SLOT_CYCLES(SLOTS)) u_dut (.clk_i, .rst_i, .addr_i, .io_strobe_i,
    .out_status_i, .mem_read_i, .mem_write_i, .data_in_strobe_i, .write_data_i,
    .peripheral_bus_clock_i(peripheral_bus_clock), .display_ctrl_data_i, .lightpen_data_i, .scan_addr_i,
    .vram_data_red_i, .vram_data_green_i, .vram_data_blue_i, .dot_i, .display_ctrl_select_o,
    .adapter_select_o, .readback_select_o, .lightpen_counter_select_o, .video_io_read_select_o,
    .read_buffer_enable_o, .readback_bus_o, .red_bank_select_o, .green_bank_select_o,
    .blue_bank_select_o, .vram_request_o, .phantom_o, .vram_ready_out_o, .vram_address_owner_o,
    .vram_address_bus_o, .vram_write_o, .vram_write_data_o, .fast_clear_o, .color_o);

  cpu_bus_model u_cpu (.clk_i, .ready_i(vram_ready_out_o), .addr_o(addr_i),
    .io_strobe_o(io_strobe_i), .out_status_o(out_status_i), .mem_read_o(mem_read_i),
    .mem_write_o(mem_write_i), .data_in_strobe_o(data_in_strobe_i),
    .write_data_o(write_data_i), .peripheral_bus_clock_o(peripheral_bus_clock));

  // Records what the CPU slot drove, whatever the output register lag is
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      summarize();
    end
    if (vram_address_owner_o === 1'h1)
    begin
      own_cnt++;
      wr_seen |= vram_write_o;
      abus_seen = vram_address_bus_o;
    end
  end

  task automatic summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task automatic wr_reg(input logic [1:0] idx, input logic [7:0] d);
    begin
      u_cpu.io_start({6'h36, idx}, 1'h1, d);
      u_cpu.bus_stop();
      repeat (3) @(posedge clk_i);
    end
  endtask

  task automatic t_reset;
    begin
      `CHECK("phantom", 1'h0, phantom_o)
      `CHECK("ready", 1'h1, vram_ready_out_o)
      `CHECK("owner", 1'h0, vram_address_owner_o)
      `CHECK("clear", 1'h0, fast_clear_o)
      `CHECK("color", 3'h0, color_o)
    end
  endtask

  task automatic t_io;
    logic [7:0] ports [6];
    logic [2:0] sel [6];
    begin
      ports = '{8'hdc, 8'hdd, 8'hd8, 8'hdb, 8'hde, 8'he0};
      sel = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h0};
      display_ctrl_data_i <= 8'h3c;
      lightpen_data_i <= 8'h4d;
      for (int i = 0; i < 6; i++)
      begin
        u_cpu.io_start(ports[i], 1'h0, 8'h00);
        `CHECK("disp", sel[i][2], display_ctrl_select_o)
        `CHECK("adpt", sel[i][1], adapter_select_o)
        `CHECK("lpen", sel[i][0], lightpen_counter_select_o)
        `CHECK("rbsel", |sel[i][2:1], readback_select_o)
        `CHECK("io_port_decoder", |sel[i], video_io_read_select_o)
        `CHECK("rbuf", |sel[i], read_buffer_enable_o)
        if (sel[i] == 3'h4) `CHECK("rd_disp", 8'h3c, readback_bus_o)
        if (sel[i] == 3'h1) `CHECK("rd_lpen", 8'h4d, readback_bus_o)
        u_cpu.bus_stop();
        repeat (2) @(posedge clk_i);
        `CHECK("rbuf_off", 1'h0, read_buffer_enable_o)
      end
    end
  endtask

  task automatic t_adapter;
    begin
      dot_i <= 3'h6;
      wr_reg(2'h0, 8'hd3);
      `CHECK("color_nodir", 3'h0, color_o)
      wr_reg(2'h3, 8'h07);
      wr_reg(2'h1, 8'h25);
      `CHECK("color", 3'h2, color_o)
      wr_reg(2'h0, 8'hdb);
      `CHECK("color_sat", 3'h3, color_o)
      wr_reg(2'h2, 8'h01);
      `CHECK("clear_on", 1'h1, fast_clear_o)
      wr_reg(2'h2, 8'h00);
      `CHECK("clear_off", 1'h0, fast_clear_o)
      u_cpu.io_start(8'hd9, 1'h0, 8'h00);
      `CHECK("offset_rd", 8'h25, readback_bus_o)
      u_cpu.bus_stop();
    end
  endtask

  task automatic t_mem;
    logic ok;
    logic [19:0] a [3];
    logic [7:0] dat [3];
    begin
      a = '{20'hd_12ab, 20'he_0001, 20'hc_ff00};
      dat = '{8'h11, 8'h22, 8'h33};
      vram_data_red_i <= 8'h11;
      vram_data_green_i <= 8'h22;
      vram_data_blue_i <= 8'h33;
      for (int b = 0; b < 3; b++)
      begin
        u_cpu.mem_start(a[b], 1'h0, 1'h0, 8'h00, ok);
        `CHECK("granted", 1'h1, ok)
        `CHECK("phantom", 1'h1, phantom_o)
        `CHECK("request", 1'h1, vram_request_o)
        `CHECK("banks", 3'h1 << b, {blue_bank_select_o, green_bank_select_o, red_bank_select_o})
        repeat (2) @(posedge clk_i);
        `CHECK("rd_data", dat[b], readback_bus_o)
        u_cpu.bus_stop();
        repeat (3) @(posedge clk_i);
        `CHECK("rd_idle", 8'h00, readback_bus_o)
      end
      own_cnt = 0;
      wr_seen = 3'h0;
      u_cpu.mem_start(20'hd_12ab, 1'h1, 1'h0, 8'h5a, ok);
      `CHECK("own_slots", SLOTS, own_cnt)
      `CHECK("wr_banks", 3'h3, wr_seen)
      `CHECK("wr_data", 8'h5a, vram_write_data_o)
      `CHECK("map_addr", 16'h37ab, abus_seen)
      u_cpu.bus_stop();
      repeat (3) @(posedge clk_i);
      `CHECK("scan", scan_addr_i, vram_address_bus_o)
      `CHECK("phantom_off", 1'h0, phantom_o)
    end
  endtask

  task automatic t_refuse;
    logic ok;
    begin
      u_cpu.mem_start(20'hd_0010, 1'h1, 1'h1, 8'h77, ok);
      `CHECK("out_cycle", 1'h0, ok)
      `CHECK("out_phantom", 1'h0, phantom_o)
      u_cpu.bus_stop();
      wr_reg(2'h0, 8'h5b);
      u_cpu.mem_start(20'he_0010, 1'h0, 1'h0, 8'h00, ok);
      `CHECK("no_enable", 1'h0, ok)
      `CHECK("no_sel", 1'h0, green_bank_select_o)
      u_cpu.bus_stop();
    end
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_io();
    t_adapter();
    t_mem();
    t_refuse();
    summarize();
  end
endmodule
`default_nettype wire
